/* design/mdsp_pkg.sv */
package mdsp_pkg;
  // Clock and link timing.
  localparam int CLK_NS = 20;
  localparam int LINK_NS = 160;
  localparam int HALF_CYC = LINK_NS / 2 / CLK_NS;
  // Serial word layout.
  localparam int WORD_BITS = 16;
  localparam int TARGET_BIT = 15;
  localparam int BIT_CNT_W = 5;
  // Bridges, regulators and chopping.
  localparam int BRIDGES = 3;
  localparam int REGS = 3;
  localparam int CHOP_PERIODS = 8;
  localparam int CHOP_W = 3;
  // Blanking lengths, least times rounded up.
  localparam int BLANK_LONG_NS = 5000;
  localparam int BLANK_SHORT_NS = 2500;
  localparam int BLANK_LONG_CYC = (BLANK_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_W = 9;
  localparam logic [1:0] CODE_LONG = 2'h2;
  localparam logic [1:0] CODE_SHORT = 2'h1;
  // Clear-input deglitch, inside the 2.5 to 10 us window.
  localparam int CLEAR_NS = 5000;
  localparam int CLEAR_CYC = CLEAR_NS / CLK_NS;
  localparam int CLEAR_W = 9;
  // Power-good delay after the regulators come up.
  localparam int PG_WAIT_MS = 120;
  localparam int PG_WAIT_CYC = PG_WAIT_MS * 1000000 / CLK_NS;
  // Configuration reset values and protection mask field.
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [15:0] EXT_RESET = 16'h0000;
  localparam int MASK_LSB = 0;
  // Switch patterns {+high, +low, -high, -low}.
  localparam logic [3:0] SW_OFF = 4'h0;
  localparam logic [3:0] SW_FWD = 4'h6;
  localparam logic [3:0] SW_REV = 4'h9;
  // Host register word indices and bits.
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_TX = 3'h1;
  localparam logic [2:0] A_STAT = 3'h2;
  localparam logic [2:0] A_IRQ = 3'h3;
  localparam logic [2:0] A_MASK = 3'h4;
  localparam int C_SLEEP = 0;
  localparam int C_A_ON = 1;
  localparam int C_A_DIR = 2;
  localparam int C_C_DIR = 3;
  localparam int I_DONE = 0;
  localparam int I_RST = 1;
  // Device power states.
  typedef enum logic [1:0] {
    PW_OFF = 2'b00,
    PW_WAIT = 2'b01,
    PW_GOOD = 2'b10,
    PW_FAULT = 2'b11
  } mdsp_pwr_t;
  // Host transfer states.
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SETUP = 3'b001,
    HS_HIGH = 3'b010,
    HS_LOW = 3'b011,
    HS_STROBE = 3'b100,
    HS_TAIL = 3'b101
  } mdsp_hst_t;
endpackage

/* design/mdsp_link_if.sv */
`timescale 1ns/1ps
// Shared pins between host controller and motor driver.
interface mdsp_link_if;
  // Sleep bar: low selects the serial port function.
  logic drive_sleep_bar;
  // Strobe in serial mode, bridge A enable otherwise.
  logic strobe_or_a_on;
  // Serial clock in serial mode, bridge A direction otherwise.
  logic clock_or_a_dir;
  // Serial data in serial mode, bridge C direction otherwise.
  logic data_or_c_dir;
  // Active-low power-good reset from the device.
  logic power_good_reset_out;
  modport host (
    output drive_sleep_bar,
    output strobe_or_a_on,
    output clock_or_a_dir,
    output data_or_c_dir,
    input power_good_reset_out
  );
  modport dev (
    input drive_sleep_bar,
    input strobe_or_a_on,
    input clock_or_a_dir,
    input data_or_c_dir,
    output power_good_reset_out
  );
endinterface // mdsp_link_if

/* design/mdsp_device.sv */
// What this block does
// - Blank sense at reversal and each chop cycle.
// - Setup bit pairs pick 5 or 2.5 us.
// - Any unmasked regulator fault shuts everything, reset low.
// - Common shutdown only while mask bits zero.
// - Supply hysteresis; ignore over/under voltage between.
// - Refuse bridges below 18 V supply.
// - Shared pins: serial when sleep low.
// - Sixteen bits, LSB first, falling clock capture.
// - Strobe rising edge loads shift register.
// - Strobe level ignored; only rising edge acts.
// - Top bit picks setup or extended setup.
// - Force sleep high until power good.
// - Config registers reset; shift register not.
// - Clear input acts within 2.5 to 10 us.
// - Clear resets config, power and bridges, not the shift register; restarts start-up.
// - Bridge drives diagonal by direction, else off.
`timescale 1ns/1ps
module mdsp_device #(
  parameter int PG_WAIT_CYC = mdsp_pkg::PG_WAIT_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Shared pins toward the host.
  mdsp_link_if.dev link,
  // Supply comparators and clear, asynchronous levels.
  input wire logic system_clear_in_bar,
  input wire logic supply_above_rise,
  input wire logic supply_above_fall,
  input wire logic supply_motor_ok,
  // Regulator channel faults, asynchronous levels.
  input wire logic [2:0] undervoltage_fault,
  input wire logic [2:0] overvoltage_fault,
  input wire logic [2:0] overcurrent_fault,
  // Chopping oscillator and unshared bridge controls.
  input wire logic chop_oscillator,
  input wire logic bridge_b_drive_on,
  input wire logic bridge_b_direction,
  input wire logic bridge_c_drive_on,
  // Power outputs.
  output logic [2:0] regulator_on,
  output wire logic [11:0] bridge_switch,
  output wire logic [2:0] sense_mask_interval,
  // Configuration readback.
  output logic [15:0] setup_word,
  output logic [15:0] ext_setup_word
);
  localparam int NSYNC = 21;
  localparam int PGW = $clog2(PG_WAIT_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: every pin passes two flops before use.
  logic [NSYNC-1:0] in_a;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic sl_w, p9_w, p10_w, p11_w, clr_w, rise_w, fall_w, mok_w;
  logic [2:0] uv_w, ov_w, oc_w;
  logic chop_w, bon_w, bdir_w, con_w;
  assign in_a = {link.drive_sleep_bar, link.strobe_or_a_on,
                 link.clock_or_a_dir, link.data_or_c_dir,
                 system_clear_in_bar, supply_above_rise, supply_above_fall,
                 supply_motor_ok, undervoltage_fault, overvoltage_fault,
                 overcurrent_fault, chop_oscillator, bridge_b_drive_on,
                 bridge_b_direction, bridge_c_drive_on};
  assign {sl_w, p9_w, p10_w, p11_w, clr_w, rise_w, fall_w, mok_w, uv_w,
          ov_w, oc_w, chop_w, bon_w, bdir_w, con_w} = s2_q;

  // The first stage is read only by the second.
  always_ff @(posedge clock) begin
    s1_q <= in_a;
    s2_q <= s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear-input deglitch.
  logic [mdsp_pkg::CLEAR_W-1:0] clr_cnt_q;
  logic clr_act_q;
  logic sys_rst;
  logic clr_done;
  assign clr_done = clr_cnt_q ==
                    mdsp_pkg::CLEAR_W'(mdsp_pkg::CLEAR_CYC - 1);
  // The clear acts on every block reset, so it is the local reset term.
  assign sys_rst = !rst_n || clr_act_q;

  always_ff @(posedge clock) begin
    if (!rst_n || clr_w) begin
      clr_cnt_q <= '0;
      clr_act_q <= 1'b0;
    end else if (clr_done) begin
      clr_act_q <= 1'b1;
    end else begin
      clr_cnt_q <= clr_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencing and fault shutdown.
  mdsp_pkg::mdsp_pwr_t pw_q, pw_d;
  logic [PGW-1:0] pg_cnt_q;
  logic [2:0] vfault;
  logic [2:0] mask_w;
  logic [2:0] choff_q;
  logic common_fault;
  logic pg_done;
  logic rst_out_q;
  // Voltage faults ignored unless above rise threshold.
  assign vfault = ((uv_w | ov_w) & {3{rise_w}}) | oc_w;
  assign mask_w = ext_setup_word[mdsp_pkg::MASK_LSB +: 3];
  // Masked channels leave the common shutdown.
  assign common_fault = |(vfault & ~mask_w);
  assign pg_done = pg_cnt_q == PGW'(PG_WAIT_CYC - 1);
  assign link.power_good_reset_out = rst_out_q;

  // Next power state.
  always_comb begin
    pw_d = pw_q;
    unique case (pw_q)
      mdsp_pkg::PW_OFF: if (rise_w) pw_d = mdsp_pkg::PW_WAIT;
      mdsp_pkg::PW_WAIT: begin
        if (!fall_w) pw_d = mdsp_pkg::PW_OFF;
        else if (common_fault) pw_d = mdsp_pkg::PW_FAULT;
        else if (pg_done) pw_d = mdsp_pkg::PW_GOOD;
      end
      mdsp_pkg::PW_GOOD: begin
        if (!fall_w) pw_d = mdsp_pkg::PW_OFF;
        else if (common_fault) pw_d = mdsp_pkg::PW_FAULT;
      end
      // A latched fault waits for the supply to drop or a clear.
      mdsp_pkg::PW_FAULT: if (!fall_w) pw_d = mdsp_pkg::PW_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pw_q <= mdsp_pkg::PW_OFF;
      pg_cnt_q <= '0;
      choff_q <= '0;
      regulator_on <= '0;
      rst_out_q <= 1'b0;
    end else begin
      pw_q <= pw_d;
      pg_cnt_q <= (pw_q == mdsp_pkg::PW_WAIT && !pg_done) ?
                  pg_cnt_q + 1'b1 : '0;
      // Selective shutdown keeps a masked channel off until restart.
      choff_q <= (pw_q == mdsp_pkg::PW_OFF) ? '0 :
                 choff_q | (vfault & mask_w);
      regulator_on <= (pw_d == mdsp_pkg::PW_WAIT ||
                       pw_d == mdsp_pkg::PW_GOOD) ?
                      ~(choff_q | (vfault & mask_w)) : '0;
      rst_out_q <= pw_d == mdsp_pkg::PW_GOOD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial setup port.
  logic sleep_bar_eff;
  logic serial_on;
  logic p9_q, p10_q, chop_q;
  logic clk_fall, stb_rise;
  logic [15:0] shift_q;
  // Sleep forced high before power good.
  assign sleep_bar_eff = (pw_q != mdsp_pkg::PW_GOOD) || sl_w;
  assign serial_on = !sleep_bar_eff;
  assign clk_fall = serial_on && p10_q && !p10_w;
  // Only the strobe rising edge acts.
  assign stb_rise = serial_on && !p9_q && p9_w;

  // Edge history of the sampled pins.
  always_ff @(posedge clock) begin
    p9_q <= p9_w;
    p10_q <= p10_w;
    chop_q <= chop_w;
  end

  always_ff @(posedge clock) begin
    if (clk_fall) begin
      shift_q <= {p11_w, shift_q[mdsp_pkg::WORD_BITS-1:1]};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      setup_word <= mdsp_pkg::SETUP_RESET;
      ext_setup_word <= mdsp_pkg::EXT_RESET;
    end else if (stb_rise) begin
      if (shift_q[mdsp_pkg::TARGET_BIT]) begin
        ext_setup_word <= shift_q;
      end else begin
        setup_word <= shift_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chopping cycle and bridge drive.
  logic [mdsp_pkg::CHOP_W-1:0] chop_cnt_q;
  logic chop_rise, chop_end, drive_ok;
  logic [2:0] en_now, dir_now, dir_q;
  assign chop_rise = chop_w && !chop_q;
  assign chop_end = chop_rise &&
      chop_cnt_q == mdsp_pkg::CHOP_W'(mdsp_pkg::CHOP_PERIODS - 1);
  assign en_now = {con_w, bon_w, p9_w};
  assign dir_now = {p11_w, bdir_w, p10_w};
  // Bridges need the 18 V range.
  assign drive_ok = pw_q == mdsp_pkg::PW_GOOD && sl_w && mok_w;

  // Chop period counter and direction history.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chop_cnt_q <= '0;
      dir_q <= '0;
    end else begin
      chop_cnt_q <= chop_rise ? chop_cnt_q + 1'b1 : chop_cnt_q;
      dir_q <= dir_now;
    end
  end

  for (genvar i = 0; i < mdsp_pkg::BRIDGES; i++) begin : g_br
    logic [1:0] code;
    logic [mdsp_pkg::BLANK_W-1:0] len, cnt_d, cnt_q;
    logic start;
    logic [3:0] sw_d, sw_q;
    logic msk_q;
    assign code = setup_word[2*i +: 2];
    assign len = (code == mdsp_pkg::CODE_LONG) ?
                 mdsp_pkg::BLANK_W'(mdsp_pkg::BLANK_LONG_CYC) :
                 (code == mdsp_pkg::CODE_SHORT) ?
                 mdsp_pkg::BLANK_W'(mdsp_pkg::BLANK_SHORT_CYC) : '0;
    // Blank at reversal or chop end.
    assign start = dir_now[i] != dir_q[i] || chop_end;
    assign cnt_d = start ? len : (cnt_q != '0) ? cnt_q - 1'b1 : '0;
    assign sw_d = (!drive_ok || !en_now[i]) ? mdsp_pkg::SW_OFF :
                  dir_now[i] ? mdsp_pkg::SW_REV : mdsp_pkg::SW_FWD;
    assign bridge_switch[4*i +: 4] = sw_q;
    assign sense_mask_interval[i] = msk_q;

    // Blanking counter and registered switch pattern.
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        cnt_q <= '0;
        msk_q <= 1'b0;
        sw_q <= mdsp_pkg::SW_OFF;
      end else begin
        cnt_q <= cnt_d;
        msk_q <= cnt_d != '0;
        sw_q <= sw_d;
      end
    end
  end
endmodule // mdsp_device

/* design/mdsp_host.sv */
`timescale 1ns/1ps
module mdsp_host #(
  parameter int HALF_CYC = mdsp_pkg::HALF_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave, word addressed.
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Level interrupt.
  output logic irq,
  // Shared pins toward the device.
  mdsp_link_if.host link
);
  localparam int DW = $clog2(HALF_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and link state.
  mdsp_pkg::mdsp_hst_t st_q, st_d;
  logic [3:0] ctrl_q;
  logic [15:0] tx_q;
  logic [mdsp_pkg::BIT_CNT_W-1:0] bit_q;
  logic [DW-1:0] div_q;
  logic [1:0] stat_q, stat_d, mask_q, ev;
  logic r1_q, r2_q, r3_q;
  logic sl_q, p9_q, p10_q, p11_q;
  logic tick, busy, last_bit, wr_fire, tx_go;
  logic [31:0] rd_val;
  assign tick = div_q == DW'(HALF_CYC - 1);
  assign busy = st_q != mdsp_pkg::HS_IDLE;
  assign last_bit = bit_q ==
                    mdsp_pkg::BIT_CNT_W'(mdsp_pkg::WORD_BITS - 1);
  assign wr_fire = avs_write && !avs_waitrequest;
  // A word written while busy is dropped.
  assign tx_go = wr_fire && avs_address == mdsp_pkg::A_TX && !busy;
  assign link.drive_sleep_bar = sl_q;
  assign link.strobe_or_a_on = p9_q;
  assign link.clock_or_a_dir = p10_q;
  assign link.data_or_c_dir = p11_q;

  // Register read selection.
  assign rd_val = (avs_address == mdsp_pkg::A_CTRL) ? 32'(ctrl_q) :
                  (avs_address == mdsp_pkg::A_TX) ? 32'(tx_q) :
                  (avs_address == mdsp_pkg::A_STAT) ? 32'({r2_q, busy}) :
                  (avs_address == mdsp_pkg::A_IRQ) ? 32'(stat_q) :
                  (avs_address == mdsp_pkg::A_MASK) ? 32'(mask_q) : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      mdsp_pkg::HS_IDLE: if (tx_go) st_d = mdsp_pkg::HS_SETUP;
      mdsp_pkg::HS_SETUP: if (tick) st_d = mdsp_pkg::HS_HIGH;
      mdsp_pkg::HS_HIGH: if (tick) st_d = mdsp_pkg::HS_LOW;
      mdsp_pkg::HS_LOW: if (tick) st_d = last_bit ?
                                  mdsp_pkg::HS_STROBE : mdsp_pkg::HS_HIGH;
      mdsp_pkg::HS_STROBE: if (tick) st_d = mdsp_pkg::HS_TAIL;
      mdsp_pkg::HS_TAIL: if (tick) st_d = mdsp_pkg::HS_IDLE;
      default: st_d = mdsp_pkg::HS_IDLE;
    endcase
  end

  // Half-period divider, bit counter and data shift.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= mdsp_pkg::HS_IDLE;
      div_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
    end else begin
      st_q <= st_d;
      div_q <= (!busy || tick) ? '0 : div_q + 1'b1;
      if (tx_go) begin
        tx_q <= avs_writedata[15:0];
        bit_q <= '0;
      end else if (st_q == mdsp_pkg::HS_LOW && tick) begin
        tx_q <= {1'b0, tx_q[15:1]};
        bit_q <= bit_q + 1'b1;
      end
    end
  end

  // Pins serial while busy, controls otherwise.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sl_q <= 1'b0;
      p9_q <= 1'b0;
      p10_q <= 1'b1;
      p11_q <= 1'b0;
    end else begin
      sl_q <= busy ? 1'b0 : ctrl_q[mdsp_pkg::C_SLEEP];
      p9_q <= busy ? st_q == mdsp_pkg::HS_STROBE : ctrl_q[mdsp_pkg::C_A_ON];
      p10_q <= busy ? st_q != mdsp_pkg::HS_LOW : ctrl_q[mdsp_pkg::C_A_DIR];
      p11_q <= busy ? tx_q[0] : ctrl_q[mdsp_pkg::C_C_DIR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, events and interrupt.
  assign ev = {r3_q && !r2_q, st_q == mdsp_pkg::HS_TAIL && tick};
  // A new event wins over a clearing write in the same cycle.
  assign stat_d = (stat_q & ~((wr_fire && avs_address == mdsp_pkg::A_IRQ) ?
                  avs_writedata[1:0] : 2'h0)) | ev;

  // Reset-out synchroniser, first stage read only by the second.
  always_ff @(posedge clock) begin
    r1_q <= link.power_good_reset_out;
    r2_q <= r1_q;
    r3_q <= r2_q;
  end

  // Waitrequest drops one cycle after a request, then rises again.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl_q <= 4'h0;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      avs_readdata <= avs_read ? rd_val : 32'h0;
      if (wr_fire && avs_address == mdsp_pkg::A_CTRL) begin
        ctrl_q <= avs_writedata[3:0];
      end
      if (wr_fire && avs_address == mdsp_pkg::A_MASK) begin
        mask_q <= avs_writedata[1:0];
      end
      stat_q <= stat_d;
      irq <= |(stat_d & mask_q);
    end
  end
endmodule // mdsp_host

/* verif/mdsp_props.sv */
`timescale 1ns/1ps
// Watches the shared pins between the host and the motor driver.
module mdsp_props #(
  parameter int PG_WAIT_CYC = 50
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Shared link signals.
  input wire logic drive_sleep_bar,
  input wire logic strobe_or_a_on,
  input wire logic clock_or_a_dir,
  input wire logic data_or_c_dir,
  input wire logic power_good_reset_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // High while the pins carry the serial port.
  wire logic ser = !drive_sleep_bar;
  // Clock falls in this frame, and low cycles of the power-good output.
  logic [4:0] falls_q;
  logic [31:0] low_q;
  ////////////////////////////////////////////////////////////
  // Falls are counted only in serial mode, so a frame starts at zero.
  always_ff @(posedge clock) begin
    if (!rst_n || !ser) falls_q <= 5'h00;
    else if ($fell(clock_or_a_dir)) falls_q <= falls_q + 5'h01;
  end
  // Counts how long the power-good output has been held low.
  always_ff @(posedge clock) begin
    if (!rst_n || power_good_reset_out) low_q <= 32'h0;
    else low_q <= low_q + 32'h1;
  end
  ////////////////////////////////////////////////////////////
  // One strobe pulse of a half bit period.
  sequence s_strobe_pulse;
    strobe_or_a_on [*4] ##1 !strobe_or_a_on;
  endsequence
  // A frame ends with a strobe after sixteen bit periods.
  sequence s_frame_to_strobe;
    ##[120:150] (ser && $rose(strobe_or_a_on));
  endsequence
  property p_pg_hold;
    $rose(rst_n) |-> !power_good_reset_out [*8];
  endproperty
  property p_pg_wait;
    $rose(power_good_reset_out) |-> low_q >= 32'(PG_WAIT_CYC);
  endproperty
  property p_bit_count;
    ser && $rose(strobe_or_a_on) |-> falls_q == 5'h10;
  endproperty
  property p_strobe_width;
    ser && $rose(strobe_or_a_on) |-> s_strobe_pulse;
  endproperty
  property p_clk_low;
    ser && $fell(clock_or_a_dir) |-> !clock_or_a_dir [*4];
  endproperty
  property p_data_stable;
    ser && $fell(clock_or_a_dir) |-> $stable(data_or_c_dir);
  endproperty
  // The serial clock rests high while the strobe is up, so nothing shifts.
  property p_clk_in_strobe;
    ser && strobe_or_a_on |-> clock_or_a_dir;
  endproperty
  property p_frame_len;
    $fell(drive_sleep_bar) && clock_or_a_dir |-> s_frame_to_strobe;
  endproperty
  a_pg_hold: assert property (p_pg_hold)
    else $error("power good released too soon after reset");
  a_pg_wait: assert property (p_pg_wait)
    else $error("power good released before the start-up wait");
  a_bit_count: assert property (p_bit_count)
    else $error("strobe after a bit count other than sixteen");
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe pulse has the wrong width");
  a_clk_low: assert property (p_clk_low)
    else $error("serial clock low phase too short");
  a_data_stable: assert property (p_data_stable)
    else $error("serial data moved at the clock fall");
  a_clk_in_strobe: assert property (p_clk_in_strobe)
    else $error("serial clock low during strobe");
  a_frame_len: assert property (p_frame_len)
    else $error("frame did not end with a strobe in time");
endmodule // mdsp_props

/* verif/motor_driver_setup_port_and_shutdown_tb_top.sv */
`timescale 1ns/1ps
// Host controller and motor driver joined over the link, driven by bus.
module motor_driver_setup_port_and_shutdown_tb_top;
  localparam int PG = 400;
  // Clock, reset and bus.
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  // Device inputs and outputs.
  logic clr_n, rise, fall, mok, chop, b_on, b_dir, c_on;
  logic [2:0] uv, ov, oc, reg_on, mask;
  logic [11:0] sw;
  logic [15:0] setup_w, ext_w;
  int fails, comparisons, cycles, n;
  mdsp_link_if link();
  mdsp_host i_mdsp_host (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
  mdsp_device #(.PG_WAIT_CYC(PG)) i_mdsp_device (.clock(clock),
    .rst_n(rst_n), .link(link), .system_clear_in_bar(clr_n),
    .supply_above_rise(rise), .supply_above_fall(fall),
    .supply_motor_ok(mok), .undervoltage_fault(uv),
    .overvoltage_fault(ov), .overcurrent_fault(oc), .chop_oscillator(chop),
    .bridge_b_drive_on(b_on), .bridge_b_direction(b_dir),
    .bridge_c_drive_on(c_on), .regulator_on(reg_on), .bridge_switch(sw),
    .sense_mask_interval(mask), .setup_word(setup_w),
    .ext_setup_word(ext_w));
  mdsp_props #(.PG_WAIT_CYC(PG)) i_mdsp_props (.clock(clock),
    .rst_n(rst_n), .drive_sleep_bar(link.drive_sleep_bar),
    .strobe_or_a_on(link.strobe_or_a_on),
    .clock_or_a_dir(link.clock_or_a_dir),
    .data_or_c_dir(link.data_or_c_dir),
    .power_good_reset_out(link.power_good_reset_out));
  ////////////////////////////////////////////////////////////
  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest) @(posedge clock);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  // Sends one word and waits for the host to finish.
  task automatic send(input logic [15:0] w);
    bus(1'b1, mdsp_pkg::A_TX, {16'h0000, w});
    bus(1'b0, mdsp_pkg::A_STAT, 32'h0);
    while (rdata[0]) bus(1'b0, mdsp_pkg::A_STAT, 32'h0);
    repeat (8) @(posedge clock);
  endtask
  // Measures the next blanking pulse of bridge i; zero if none comes.
  task automatic blank_len(input int i, input int exp);
    n = 0;
    while (!mask[i] && n < 50) begin
      n++;
      @(posedge clock);
    end
    n = 0;
    while (mask[i]) begin
      n++;
      @(posedge clock);
    end
    check(32'(n), 32'(exp));
  endtask
  // Eight chop edges; the last one starts a chop blanking.
  task automatic chop8();
    repeat (8) begin
      chop <= 1'b0;
      repeat (2) @(posedge clock);
      chop <= 1'b1;
      @(posedge clock);
    end
  endtask
  // Waits for the power-good output.
  task automatic wait_pg();
    while (link.power_good_reset_out !== 1'b1) @(posedge clock);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    {rst_n, avs_read, avs_write, rise, fall, mok} = 6'h00;
    {chop, b_on, b_dir, c_on, uv, ov, oc} = 13'h0000;
    {avs_address, avs_writedata, clr_n} = 36'h000000001;
    {fails, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(32'(setup_w), 32'h0);
    check(32'(ext_w), 32'h0);
    check(32'(reg_on), 32'h0);
    bus(1'b0, 3'h7, 32'h0);
    check(rdata, 32'h0);
    bus(1'b1, mdsp_pkg::A_CTRL, 32'h1);
    $display("test reset done");
    {rise, fall, mok} <= 3'h7;
    send(16'h0006);
    check(32'(setup_w), 32'h0);
    wait_pg();
    check(32'(reg_on), 32'h7);
    bus(1'b0, mdsp_pkg::A_IRQ, 32'h0);
    check(32'(rdata[0]), 32'h1);
    check(32'(irq), 32'h0);
    bus(1'b1, mdsp_pkg::A_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h1);
    bus(1'b1, mdsp_pkg::A_IRQ, 32'h3);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0);
    $display("test start-up done");
    send(16'h0006);
    check(32'(setup_w), 32'h0006);
    send(16'h8000);
    check(32'(ext_w), 32'h8000);
    check(32'(setup_w), 32'h0006);
    $display("test serial done");
    {b_on, c_on} <= 2'h3;
    bus(1'b1, mdsp_pkg::A_CTRL, 32'h3);
    repeat (6) @(posedge clock);
    check(32'(sw[3:0]), 32'(mdsp_pkg::SW_FWD));
    // The pins falling back to idle after a frame is a reversal; let it end.
    while (mask[0]) @(posedge clock);
    bus(1'b1, mdsp_pkg::A_CTRL, 32'h7);
    blank_len(0, mdsp_pkg::BLANK_LONG_CYC);
    check(32'(sw[3:0]), 32'(mdsp_pkg::SW_REV));
    b_dir <= 1'b1;
    blank_len(1, mdsp_pkg::BLANK_SHORT_CYC);
    bus(1'b1, mdsp_pkg::A_CTRL, 32'hf);
    blank_len(2, 0);
    chop8();
    blank_len(0, mdsp_pkg::BLANK_LONG_CYC);
    mok <= 1'b0;
    repeat (8) @(posedge clock);
    check(32'(sw), 32'h0);
    mok <= 1'b1;
    bus(1'b1, mdsp_pkg::A_CTRL, 32'h5);
    repeat (6) @(posedge clock);
    check(32'(sw[3:0]), 32'h0);
    bus(1'b1, mdsp_pkg::A_CTRL, 32'h0);
    repeat (6) @(posedge clock);
    check(32'(sw), 32'h0);
    bus(1'b1, mdsp_pkg::A_CTRL, 32'h1);
    $display("test bridges done");
    rise <= 1'b0;
    {uv, ov} <= 6'h22;
    repeat (8) @(posedge clock);
    check(32'(reg_on), 32'h7);
    {uv, ov, rise} <= 7'h01;
    send(16'h8001);
    oc <= 3'h1;
    repeat (8) @(posedge clock);
    check(32'(reg_on), 32'h6);
    check(32'(link.power_good_reset_out), 32'h1);
    oc <= 3'h0;
    send(16'h8000);
    oc <= 3'h2;
    repeat (8) @(posedge clock);
    check(32'(reg_on), 32'h0);
    check(32'(sw), 32'h0);
    check(32'(link.power_good_reset_out), 32'h0);
    bus(1'b0, mdsp_pkg::A_IRQ, 32'h0);
    check(32'(rdata[1]), 32'h1);
    {oc, rise, fall} <= 5'h00;
    repeat (8) @(posedge clock);
    {rise, fall} <= 2'h3;
    wait_pg();
    $display("test faults done");
    send(16'h0006);
    clr_n <= 1'b0;
    n = 0;
    while (reg_on !== 3'h0 && n < 600) begin
      n++;
      @(posedge clock);
    end
    check(32'(n > 125 && n < 500), 32'h1);
    check(32'(setup_w), 32'h0);
    clr_n <= 1'b1;
    wait_pg();
    check(32'(reg_on), 32'h7);
    $display("test clear done");
    close_out();
  end
endmodule // motor_driver_setup_port_and_shutdown_tb_top
